// [rtl/fsp_ctrl.sv]
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES   = PROG_CYC,
    parameter int UNLOCK_CYCLES = UNLOCK_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic                    wb_ack_o,
    output logic                    irq,
    output logic                    cpu_stall,
    output logic      [ADDR_W-1:0]  fl_addr,
    output logic      [WORD_W-1:0]  fl_wdata,
    output logic                    fl_we,
    output logic                    fl_erase,
    output logic                    fl_re,
    input  wire logic [WORD_W-1:0]  fl_rdata
);
    fsp_wbuf_if bus ();
    fsp_state_t        state_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    logic              prog_trig_q;
    logic              read_trig_q;
    logic              read_en_q;
    logic              arm_q;
    logic              unlocked_q;
    logic [2:0]        op_q;
    logic              clr_req_q;
    logic [7:0]        addr_lo_q;
    logic [5:0]        addr_hi_q;
    logic [7:0]        aux_q [8];
    logic [5:0]        idx_q;
    logic [5:0]        stream_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  arm_cnt_q;
    logic [ST_BITS-1:0] status_q;
    logic [ST_BITS-1:0] mask_q;
    logic [ST_BITS-1:0] ev;
    logic              wr_acc;
    logic              rd_acc;
    logic [7:0]        wv;
    logic [7:0]        ctrl0_rd;
    logic [7:0]        rd_mux;
    logic              pat_ok;
    logic              start_erase;
    logic              start_prog;
    logic              start_read;
    logic              prog_done;
    logic              read_done;
    logic              arm_expire;
    fsp_wbuf #(
        .DEPTH (BUF_WORDS)
    ) u_wbuf (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .bp      (bus.buff)
    );
    //----------------------------------------------------------------
    // wishbone slave
    //----------------------------------------------------------------
    // writes land on the edge where ack is high, as the master sees it
    assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign rd_acc = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
    assign wv     = wb_dat_i[7:0];
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end
    assign ctrl0_rd = {op_q, unlocked_q, arm_q, read_en_q, read_trig_q, prog_trig_q};
    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (wb_adr_i)
            REG_CTRL0:   rd_mux = ctrl0_rd;
            REG_CTRL2:   rd_mux = {7'h00, clr_req_q};
            REG_ADDR_LO: rd_mux = addr_lo_q;
            REG_ADDR_HI: rd_mux = {2'h0, addr_hi_q};
            REG_D0_LO:   rd_mux = aux_q[0];
            REG_D0_HI:   rd_mux = aux_q[1];
            REG_D1_LO:   rd_mux = aux_q[2];
            REG_D1_HI:   rd_mux = aux_q[3];
            REG_D2_LO:   rd_mux = aux_q[4];
            REG_D2_HI:   rd_mux = aux_q[5];
            REG_D3_LO:   rd_mux = aux_q[6];
            REG_D3_HI:   rd_mux = aux_q[7];
            REG_STATUS:  rd_mux = {4'h0, status_q};
            REG_MASK:    rd_mux = {4'h0, mask_q};
            default:     rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dat_q <= 32'h0000_0000;
        end else if (rd_acc) begin
            dat_q <= {24'h00_0000, rd_mux};
        end
    end
    //----------------------------------------------------------------
    // operation launch decode
    //----------------------------------------------------------------
    // triggers are only honoured from idle; a busy engine ignores them
    // erase needs unlock
    assign start_erase = wr_acc && wb_adr_i == REG_CTRL0 && wv[CTL_PROG_TRIG]
                         && wv[CTL_OP_LSB +: 3] == OP_ERASE && unlocked_q
                         && state_q == S_IDLE && !clr_req_q;
    assign start_prog  = wr_acc && wb_adr_i == REG_CTRL0 && wv[CTL_PROG_TRIG]
                         && wv[CTL_OP_LSB +: 3] == OP_WRITE && unlocked_q
                         && state_q == S_IDLE && !clr_req_q;
    assign start_read  = wr_acc && wb_adr_i == REG_CTRL0 && wv[CTL_READ_TRIG]
                         && wv[CTL_OP_LSB +: 3] == OP_READ && wv[CTL_READ_EN]
                         && state_q == S_IDLE;
    assign prog_done   = (state_q == S_ERASE || state_q == S_WAIT) && cnt_q == CNT_W'(1);
    assign read_done   = state_q == S_READ && cnt_q == CNT_W'(1);
    assign arm_expire  = arm_q && arm_cnt_q == CNT_W'(1);
    assign pat_ok = aux_q[2] == PAT_D1_LO && aux_q[4] == PAT_D2_LO && aux_q[6] == PAT_D3_LO
                 && aux_q[3] == PAT_D1_HI && aux_q[5] == PAT_D2_HI && aux_q[7] == PAT_D3_HI;
    //----------------------------------------------------------------
    // control register 0
    //----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            op_q        <= 3'h0;
            read_en_q   <= 1'b0;
            prog_trig_q <= 1'b0;
            read_trig_q <= 1'b0;
        end else begin
            if (wr_acc && wb_adr_i == REG_CTRL0 && state_q == S_IDLE) begin
                op_q      <= wv[CTL_OP_LSB +: 3];
                read_en_q <= wv[CTL_READ_EN];
            end
            prog_trig_q <= start_erase || start_prog || (prog_trig_q && !prog_done);
            read_trig_q <= start_read || (read_trig_q && !read_done);
        end
    end
    //----------------------------------------------------------------
    // unlock sequence
    //----------------------------------------------------------------
    // the arm bit cannot be cleared early by software; only the timer ends it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            arm_q      <= 1'b0;
            arm_cnt_q  <= '0;
            unlocked_q <= 1'b0;
        end else begin
            if (!arm_q && wr_acc && wb_adr_i == REG_CTRL0 && wv[CTL_ARM]
                    && wv[CTL_OP_LSB +: 3] == OP_UNLOCK) begin
                arm_q     <= 1'b1;
                arm_cnt_q <= CNT_W'(UNLOCK_CYCLES);
            end else if (arm_expire) begin
                arm_q <= 1'b0;
            end else if (arm_q) begin
                arm_cnt_q <= arm_cnt_q - CNT_W'(1);
            end
            if (arm_expire && pat_ok) begin
                unlocked_q <= 1'b1;
            end else if (wr_acc && wb_adr_i == REG_CTRL0 && !wv[CTL_UNLOCKED]) begin
                unlocked_q <= 1'b0;
            end
        end
    end
    //----------------------------------------------------------------
    // address and data registers
    //----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addr_lo_q <= 8'h00;
            addr_hi_q <= 6'h00;
            idx_q     <= 6'h00;
            aux_q     <= '{default: 8'h00};
        end else begin
            if (wr_acc && wb_adr_i == REG_ADDR_LO) begin
                addr_lo_q <= wv;
                idx_q     <= wv[PAGE_BITS-1:0];
            end
            if (wr_acc && wb_adr_i == REG_ADDR_HI) begin
                addr_hi_q <= wv[5:0];
            end
            for (int i = 0; i < 8; i++) begin
                if (wr_acc && wb_adr_i == REG_D0_LO + 8'(4 * i)) begin
                    aux_q[i] <= wv;
                end
            end
            // index steps, stops at page end
            if (wr_acc && wb_adr_i == REG_D0_HI && idx_q != 6'(BUF_WORDS - 1)) begin
                idx_q <= idx_q + 6'h01;
            end
            if (read_done) begin
                aux_q[0] <= fl_rdata[7:0];
                aux_q[1] <= fl_rdata[15:8];
            end
        end
    end

    assign bus.wr_en   = wr_acc && wb_adr_i == REG_D0_HI;
    assign bus.wr_idx  = idx_q;
    assign bus.wr_data = {wv, aux_q[0]};
    assign bus.rd_idx  = stream_q;
    assign bus.clr_req = clr_req_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clr_req_q <= 1'b0;
        end else if (wr_acc && wb_adr_i == REG_CTRL2 && wv[0] && state_q == S_IDLE) begin
            clr_req_q <= 1'b1;
        end else if (bus.clr_done) begin
            clr_req_q <= 1'b0;
        end
    end

    //----------------------------------------------------------------
    // operation engine
    //----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q   <= S_IDLE;
            cnt_q     <= '0;
            stream_q  <= 6'h00;
            fl_addr   <= '0;
            fl_wdata  <= '0;
            fl_we     <= 1'b0;
            fl_erase  <= 1'b0;
            fl_re     <= 1'b0;
            cpu_stall <= 1'b0;
        end else begin
            fl_we    <= 1'b0;
            fl_erase <= 1'b0;
            fl_re    <= 1'b0;
            unique case (state_q)
                S_IDLE: begin
                    stream_q <= 6'h00;
                    if (start_erase) begin
                        state_q   <= S_ERASE;
                        cnt_q     <= CNT_W'(PROG_CYCLES);
                        fl_erase  <= 1'b1;
                        fl_addr   <= {addr_hi_q, addr_lo_q[7:PAGE_BITS], 6'h00};
                        cpu_stall <= 1'b1;
                    end else if (start_prog) begin
                        state_q   <= S_PROG;
                        cnt_q     <= CNT_W'(PROG_CYCLES);
                        cpu_stall <= 1'b1;
                    end else if (start_read) begin
                        state_q   <= S_READ;
                        cnt_q     <= CNT_W'(READ_CYC);
                        fl_re     <= 1'b1;
                        fl_addr   <= {addr_hi_q, addr_lo_q};
                        cpu_stall <= 1'b1;
                    end
                end
                S_PROG: begin
                    cnt_q    <= cnt_q - CNT_W'(1);
                    fl_we    <= 1'b1;
                    fl_wdata <= bus.rd_data;
                    fl_addr  <= {addr_hi_q, addr_lo_q[7:PAGE_BITS], stream_q};
                    stream_q <= stream_q + 6'h01;
                    if (stream_q == 6'(BUF_WORDS - 1)) begin
                        state_q <= S_WAIT;
                    end
                end
                S_ERASE, S_WAIT: begin
                    cnt_q <= cnt_q - CNT_W'(1);
                    if (prog_done) begin
                        state_q   <= S_IDLE;
                        cpu_stall <= 1'b0;
                    end
                end
                S_READ: begin
                    cnt_q <= cnt_q - CNT_W'(1);
                    if (read_done) begin
                        state_q   <= S_IDLE;
                        cpu_stall <= 1'b0;
                    end
                end
                default: begin
                    state_q   <= S_IDLE;
                    cpu_stall <= 1'b0;
                end
            endcase
        end
    end

    //----------------------------------------------------------------
    // interrupt status
    //----------------------------------------------------------------
    // erase/write completion, read completion and unlock pass/fail reported
    assign ev = {arm_expire && !pat_ok, arm_expire && pat_ok, read_done, prog_done};

    // an event in the clearing read survives: set wins over clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= '0;
            mask_q   <= '0;
            irq      <= 1'b0;
        end else begin
            if (rd_acc && wb_adr_i == REG_STATUS) begin
                status_q <= ev;
            end else begin
                status_q <= status_q | ev;
            end
            if (wr_acc && wb_adr_i == REG_MASK) begin
                mask_q <= wv[ST_BITS-1:0];
            end
            irq <= |(status_q & mask_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule
`default_nettype wire

// [rtl/fsp_pkg.sv]
//------------------------------------------------------------------------------
// Summary of operation
// - op select 001 plus program trigger erases the addressed page, then trigger clears.
// - op select 000 is write mode; trigger copies write buffer into the page.
// - program trigger stays high for the 2.2 ms operation, then clears.
// - cpu stalls while erase, write or read is in progress.
// - erase and write run only while the unlocked flag is high.
// - erase always clears a whole page, never one word.
// - write programs the whole buffer as one page, never crossing a page.
// - after buffer clear and reload, repeat writes to an unerased page are accepted.
// - read: op 011, read enable, address, read trigger; data shown when trigger clears.
// - read trigger clears about three instruction cycles after being set.
// - reads need no unlock.
// - clearing unlocked flag blocks erase and write until unlock is redone.
// - op 110 plus arm starts timer; pattern in aux regs sets unlocked at timeout.
// - buffer clear request empties the buffer, then hardware clears the bit.
// - buffer holds 64 words; index steps after each data high write, stops at 63.
//------------------------------------------------------------------------------
`default_nettype none
package fsp_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [7:0] REG_CTRL0   = 8'h00;
    localparam logic [7:0] REG_CTRL2   = 8'h04;
    localparam logic [7:0] REG_ADDR_LO = 8'h08;
    localparam logic [7:0] REG_ADDR_HI = 8'h0c;
    localparam logic [7:0] REG_D0_LO   = 8'h10;
    localparam logic [7:0] REG_D0_HI   = 8'h14;
    localparam logic [7:0] REG_D1_LO   = 8'h18;
    localparam logic [7:0] REG_D1_HI   = 8'h1c;
    localparam logic [7:0] REG_D2_LO   = 8'h20;
    localparam logic [7:0] REG_D2_HI   = 8'h24;
    localparam logic [7:0] REG_D3_LO   = 8'h28;
    localparam logic [7:0] REG_D3_HI   = 8'h2c;
    localparam logic [7:0] REG_STATUS  = 8'h30;
    localparam logic [7:0] REG_MASK    = 8'h34;
    // control register 0 fields
    localparam int CTL_PROG_TRIG = 0;
    localparam int CTL_READ_TRIG = 1;
    localparam int CTL_READ_EN   = 2;
    localparam int CTL_ARM       = 3;
    localparam int CTL_UNLOCKED  = 4;
    localparam int CTL_OP_LSB    = 5;
    // operation select codes
    localparam logic [2:0] OP_WRITE  = 3'h0;
    localparam logic [2:0] OP_ERASE  = 3'h1;
    localparam logic [2:0] OP_READ   = 3'h3;
    localparam logic [2:0] OP_UNLOCK = 3'h6;
    // status and mask bit positions
    localparam int ST_PROG_DONE = 0;
    localparam int ST_READ_DONE = 1;
    localparam int ST_UNLOCK_OK = 2;
    localparam int ST_UNLOCK_NG = 3;
    localparam int ST_BITS      = 4;
    // unlock pattern for aux regs 1 lo, 2 lo, 3 lo, 1 hi, 2 hi, 3 hi
    localparam logic [7:0] PAT_D1_LO = 8'h00;
    localparam logic [7:0] PAT_D2_LO = 8'h0d;
    localparam logic [7:0] PAT_D3_LO = 8'hc3;
    localparam logic [7:0] PAT_D1_HI = 8'h04;
    localparam logic [7:0] PAT_D2_HI = 8'h09;
    localparam logic [7:0] PAT_D3_HI = 8'h40;
    // geometry
    localparam int ADDR_W    = 14;
    localparam int WORD_W    = 16;
    localparam int PAGE_BITS = 6;
    localparam int PAGE_W    = ADDR_W - PAGE_BITS;
    localparam int BUF_WORDS = 64;
    // timing
    localparam int CLK_KHZ        = 10_000;
    localparam int PROG_TIME_US   = 2200;
    localparam int PROG_CYC       = PROG_TIME_US * CLK_KHZ / 1000;
    localparam int CLK_PER_INSTR  = 4;
    localparam int READ_INSTR     = 3;
    localparam int READ_CYC       = READ_INSTR * CLK_PER_INSTR;
    localparam int UNLOCK_CYC     = 256;
    localparam int CNT_W          = 24;
    // controller states
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ERASE = 3'b001,
        S_PROG  = 3'b010,
        S_WAIT  = 3'b011,
        S_READ  = 3'b100
    } fsp_state_t;
endpackage
`default_nettype wire

// [rtl/fsp_wbuf_if.sv]
`timescale 1ns/10ps
`default_nettype none
// write buffer port between controller and buffer store
interface fsp_wbuf_if;
    logic        clr_req;
    logic        clr_done;
    logic        wr_en;
    logic [5:0]  wr_idx;
    logic [15:0] wr_data;
    logic [5:0]  rd_idx;
    logic [15:0] rd_data;
    modport ctrl (output clr_req, wr_en, wr_idx, wr_data, rd_idx, input clr_done, rd_data);
    modport buff (input clr_req, wr_en, wr_idx, wr_data, rd_idx, output clr_done, rd_data);
endinterface
`default_nettype wire

// [rtl/fsp_wbuf.sv]
`timescale 1ns/10ps
`default_nettype none
module fsp_wbuf
    import fsp_pkg::*;
#(
    parameter int DEPTH = BUF_WORDS
) (
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    fsp_wbuf_if.buff   bp
);
    logic [WORD_W-1:0] mem_q [DEPTH];
    logic [5:0]        sweep_q;
    logic              done_q;

    //----------------------------------------------------------------
    // clear sweep
    //----------------------------------------------------------------
    // one word per cycle keeps the store a plain single-port array
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sweep_q <= 6'h00;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (bp.clr_req && !done_q) begin
                sweep_q <= sweep_q + 6'h01;
                if (sweep_q == 6'(DEPTH - 1)) begin
                    sweep_q <= 6'h00;
                    done_q  <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (bp.clr_req && !done_q) begin
            mem_q[sweep_q] <= '0;
        end else if (bp.wr_en) begin
            mem_q[bp.wr_idx] <= bp.wr_data;
        end
    end

    assign bp.rd_data  = mem_q[bp.rd_idx];
    assign bp.clr_done = done_q;
endmodule
`default_nettype wire

// [tb/fsp_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// port checker for the self-programming control
// ------------------------------------------
module fsp_ctrl_chk
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES   = PROG_CYC,
    parameter int UNLOCK_CYCLES = UNLOCK_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_ack_o,
    input  wire logic              cpu_stall,
    input  wire logic [ADDR_W-1:0] fl_addr,
    input  wire logic              fl_we,
    input  wire logic              fl_erase,
    input  wire logic              fl_re
);
    logic [CNT_W-1:0] run_q;
    logic             prog_q;
    // length of the current stall
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !cpu_stall) begin
            run_q <= '0;
        end else begin
            run_q <= run_q + 1'b1;
        end
    end
    // remembers whether the last operation was erase/write, not read
    always_ff @(posedge sys_clk) begin
        if (sys_rst || fl_re) begin
            prog_q <= 1'b0;
        end else if (fl_erase || fl_we) begin
            prog_q <= 1'b1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_LAT: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_REQ: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack without request");
    AST_ERASE_PAGE: assert property (fl_erase |-> fl_addr[5:0] == 6'h00 && cpu_stall)
        else $error("erase not page aligned or cpu running");
    AST_WE_STEP: assert property (fl_we && $past(fl_we) |->
        $past(fl_addr[5:0]) != 6'h3f && fl_addr == $past(fl_addr) + 1'b1)
        else $error("write run leaves page or skips word");
    AST_WE_START: assert property ($rose(fl_we) |-> fl_addr[5:0] == 6'h00 && cpu_stall)
        else $error("write run not from word zero");
    AST_PROG_LEN: assert property ($fell(cpu_stall) && prog_q |->
        run_q >= PROG_CYCLES - 2 && run_q <= PROG_CYCLES + 1)
        else $error("erase or write stall length wrong");
    AST_READ_LEN: assert property (fl_re |-> cpu_stall ##1 cpu_stall[*8] ##[1:8] !cpu_stall)
        else $error("read stall length wrong");
    AST_ONE_OP: assert property ($onehot0({fl_we, fl_erase, fl_re}))
        else $error("flash strobes overlap");
endmodule
`default_nettype wire

// [tb/flash_self_programming_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_self_programming_ctrl_tb;
    import fsp_pkg::*;
    localparam int PC = 100;
    localparam int UC = 20;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic [31:0] dato, rdat;
    logic        ack, irq, cpu_stall, fl_we, fl_erase, fl_re;
    logic [13:0] fl_addr, ers_addr, a;
    logic [15:0] fl_wdata, e;
    logic [15:0] fl_rdata = 16'h0000;
    logic [15:0] wmem [64];
    logic [15:0] exp_mem [64];
    logic [31:0] seed = 32'd50581;
    int          wcnt, stall_n, n_fail, checks, cyc_n, k;
    fsp_ctrl #(.PROG_CYCLES(PC), .UNLOCK_CYCLES(UC)) u_dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_we_i(we),
        .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq(irq),
        .cpu_stall(cpu_stall), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we),
        .fl_erase(fl_erase), .fl_re(fl_re), .fl_rdata(fl_rdata));
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] fmem(input logic [13:0] p);
        return {p[7:0] ^ 8'ha5, 2'b00, p[13:8]};
    endfunction
    // flash stand-in, strobe capture and run limit
    always @(posedge sys_clk) begin
        if (fl_re) fl_rdata <= fmem(fl_addr);
        if (fl_we) begin
            wmem[fl_addr[5:0]] <= fl_wdata;
            wcnt <= wcnt + 1;
        end
        if (fl_erase) ers_addr <= fl_addr;
        if (cpu_stall) stall_n <= stall_n + 1;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {24'h0, d};
        do @(posedge sys_clk); while (ack !== 1'b1);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] x);
        wb(1'b0, ad, 8'h00);
        check(rdat, {24'h0, x});
    endtask
    task automatic run(input logic [7:0] ctl);
        stall_n = 0;
        wb(1'b1, REG_CTRL0, ctl);
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 400 && cpu_stall !== 1'b0; i++) @(posedge sys_clk);
    endtask
    task automatic set_addr(input logic [13:0] p);
        wb(1'b1, REG_ADDR_LO, p[7:0]);
        wb(1'b1, REG_ADDR_HI, {2'b00, p[13:8]});
    endtask
    task automatic unlock(input logic [7:0] f);
        wb(1'b1, REG_CTRL0, {OP_UNLOCK, 5'h08});
        wb(1'b1, REG_D1_LO, PAT_D1_LO ^ f);
        wb(1'b1, REG_D2_LO, PAT_D2_LO);
        wb(1'b1, REG_D3_LO, PAT_D3_LO);
        wb(1'b1, REG_D1_HI, PAT_D1_HI);
        wb(1'b1, REG_D2_HI, PAT_D2_HI);
        wb(1'b1, REG_D3_HI, PAT_D3_HI);
        repeat (UC + 4) @(posedge sys_clk);
        wb(1'b0, REG_CTRL0, 8'h00);
    endtask
    // clears the buffer, loads n random words from p, programs and compares the page
    task automatic page(input logic [13:0] p, input int n);
        logic [5:0] ix;
        for (int j = 0; j < 64; j++) exp_mem[j] = 16'h0000;
        wb(1'b1, REG_CTRL2, 8'h01);
        repeat (70) @(posedge sys_clk);
        rd_chk(REG_CTRL2, 8'h00);
        ix = p[5:0];
        set_addr(p);
        for (int j = 0; j < n; j++) begin
            seed = xs(seed);
            wb(1'b1, REG_D0_LO, seed[7:0]);
            wb(1'b1, REG_D0_HI, seed[15:8]);
            exp_mem[ix] = seed[15:0];
            if (ix != 6'h3f) ix = ix + 1'b1;
        end
        wcnt = 0;
        run(8'h11);
        check(stall_n, PC);
        check(wcnt, 64);
        for (int j = 0; j < 64; j++) check(wmem[j], exp_mem[j]);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(REG_CTRL0, 8'h00);
        rd_chk(8'h3c, 8'h00);
        run(8'h21);
        check(stall_n, 0);
        rd_chk(REG_STATUS, 8'h00);
        wb(1'b1, REG_MASK, 8'h02);
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            a = seed[13:0];
            e = fmem(a);
            set_addr(a);
            run(8'h66);
            check(stall_n, READ_CYC);
            rd_chk(REG_CTRL0, {OP_READ, 5'h04});
            rd_chk(REG_D0_LO, e[7:0]);
            rd_chk(REG_D0_HI, e[15:8]);
            check(irq, 1'b1);
            rd_chk(REG_STATUS, 8'h02);
            repeat (2) @(posedge sys_clk);
            check(irq, 1'b0);
        end
        unlock(8'h01);
        check(rdat[4:3], 2'b00);
        rd_chk(REG_STATUS, 8'h08);
        unlock(8'h00);
        check(rdat[4:3], 2'b10);
        rd_chk(REG_STATUS, 8'h04);
        seed = xs(seed);
        a = seed[13:0];
        set_addr(a);
        run(8'h31);
        check(ers_addr, {a[13:6], 6'h00});
        check(stall_n, PC);
        wb(1'b0, REG_CTRL0, 8'h00);
        check(rdat[0], 1'b0);
        rd_chk(REG_STATUS, 8'h01);
        page({a[13:6], 6'd60}, 6);
        page({a[13:6], 6'd5}, 1);
        wb(1'b1, REG_CTRL0, 8'h00);
        run(8'h31);
        check(stall_n, 0);
        rd_chk(REG_CTRL0, 8'h20);
        results();
    end
endmodule
bind fsp_ctrl fsp_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES), .UNLOCK_CYCLES(UNLOCK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .cpu_stall(cpu_stall), .fl_addr(fl_addr), .fl_we(fl_we),
    .fl_erase(fl_erase), .fl_re(fl_re));
`default_nettype wire
